// [bcslm_pkg.sv]
// Constants for the converter clock sync and load meter block
package bcslm_pkg;
   localparam int CLK_MHZ = 125;
   localparam int MEAS_TIME_US = 50;
   localparam int MEAS_CYCLES = MEAS_TIME_US * CLK_MHZ;
   localparam int RES_W = 9;
   localparam int RES_LO_W = 8;
   localparam int LOAD_LSB_MA = 20;
   localparam int LOAD_MAX_MA = 10220;
   localparam int PWM_LOAD_MA = 600;
   localparam int FREQ_W = 5;
   localparam logic [4:0] FREQ_MIN_MHZ = 5'h01;
   localparam logic [4:0] FREQ_MAX_MHZ = 5'h18;
   localparam int TOL_LO_PCT = 30;
   localparam int TOL_HI_PCT = 10;
   localparam int PER_W = 11;
   localparam logic [2:0] GOOD_N = 3'h4;
   localparam int DITHER_W = 4;
   localparam int DIV_W = 4;
   localparam logic [3:0] DITHER_DIV = 4'hf;
   localparam int CFG_W = 22;
   localparam int CFG_VSET_LSB = 0;
   localparam int CFG_FPWM_BIT = 8;
   localparam int CFG_ILIM_LSB = 9;
   localparam int CFG_SLEW_LSB = 11;
   localparam int CFG_DLY_ON_LSB = 14;
   localparam int CFG_DLY_OFF_LSB = 18;
   typedef enum logic [0:0] {
      M_IDLE = 1'b0,
      M_RUN = 1'b1
   } bcslm_meas_e;
endpackage : bcslm_pkg

// [bcslm_top.sv]
// Converter clock selection, sync check, dither, mode control and load meter
// Notes on behaviour
// (R1) A select input chooses which converter core is measured.
// (R2) Each write to the measurement select starts a fresh measurement.
// (R3) The measured core is forced to PWM while measuring.
// (R4) A measurement completes within 50 us of its start.
// (R5) Completion sets a sticky done flag; a mask bit hides its interrupt.
// (R6) The 9-bit result is split: low byte and a separate top bit.
// (R7) One result code step is 20 mA; full code means 10.22 A.
// (R8) Frequency dither only runs while the internal oscillator is used.
// (R9) One dither enable acts on both cores together.
// (R10) Dither sweeps the frequency around the nominal centre.
// (R11) Clock choice and sync interrupt follow PLL enable and clock validity.
// (R12) A mask bit hides the sync clock interrupt.
// (R13) A 5-bit field gives the expected sync frequency, 1 to 24 MHz.
// (R14) Sync clock is valid only within -30% to +10% of nominal.
// (R15) With PLL on, a missing clock at startup or activation interrupts.
// (R16) Without forced PWM a light load drops the core into PFM.
// (R17) Forced PWM keeps fixed frequency and never enters PFM.
// (R18) The sync pin can serve as a second general output instead.
// (R19) Each general output is open-drain or push-pull by choice.
// (R20) Core settings load from OTP defaults and registers may override them.
// (R21) With PLL on, clock appearing or vanishing interrupts; off, none.
// (R22) Result stays unchanged until the next measurement completes.
// (R23) Losing the sync clock falls back to the internal oscillator.
`timescale 1ns/1ns
`default_nettype none
module bcslm_top #(
   parameter int MEAS_CYCLES = bcslm_pkg::MEAS_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic meas_sel_write,
   input wire logic meas_core_sel,
   input wire logic [bcslm_pkg::RES_W-1:0] load_sense_code,
   input wire logic meas_done_mask,
   input wire logic meas_done_clear,
   output logic meas_done_flag,
   output logic meas_done_irq,
   output logic meas_busy,
   output logic [bcslm_pkg::RES_LO_W-1:0] load_result_low,
   output logic load_result_high,
   input wire logic freq_dither_enable,
   output logic dither_active,
   output logic [bcslm_pkg::DITHER_W-1:0] dither_code,
   input wire logic pll_enable,
   input wire logic [bcslm_pkg::FREQ_W-1:0] sync_nominal_freq,
   input wire logic sync_clock_pin_in,
   output logic sync_clock_pin_out,
   output logic sync_clock_pin_oe_n,
   input wire logic sync_clk_mask,
   input wire logic sync_clk_clear,
   input wire logic startup_to_standby,
   input wire logic standby_to_active,
   output logic sync_clk_flag,
   output logic sync_clk_irq,
   output logic sync_clock_valid,
   output logic ext_clk_select,
   input wire logic [1:0] light_load,
   output logic [1:0] force_pwm,
   output logic [1:0] pfm_select,
   input wire logic [2*bcslm_pkg::CFG_W-1:0] otp_cfg,
   input wire logic [1:0] cfg_write,
   input wire logic [bcslm_pkg::CFG_W-1:0] cfg_wdata,
   output logic [2*bcslm_pkg::CFG_W-1:0] core_cfg,
   input wire logic general_output_value,
   input wire logic general_output_push_pull,
   output logic general_output_out,
   output logic general_output_oe_n,
   input wire logic second_general_output_enable,
   input wire logic second_general_output_value,
   input wire logic second_general_output_push_pull
);
   localparam int CNT_W = $clog2(MEAS_CYCLES + 1);
   localparam logic [CNT_W-1:0] MEAS_LAST = CNT_W'(MEAS_CYCLES - 1);

   // Period bound in clock cycles for a frequency offset of pct percent;
   // the short bound rounds up so that a clock above +10% is never accepted
   function automatic logic [bcslm_pkg::PER_W-1:0] per_bound(
      input logic [bcslm_pkg::FREQ_W-1:0] f, input int pct, input logic up);
      int num;
      int den;
      num = bcslm_pkg::CLK_MHZ * 100;
      den = (100 + pct) * ((f == 5'h00) ? 1 : int'(f));
      return bcslm_pkg::PER_W'(up ? (num + den - 1) / den : num / den);
   endfunction : per_bound

   // Open-drain releases on a high level; push-pull always drives
   function automatic logic drive_oe_n(input logic val, input logic pp);
      return !(pp || !val);
   endfunction : drive_oe_n

   // Load meter
   bcslm_pkg::bcslm_meas_e meas_state_q, meas_state_d;
   logic [CNT_W-1:0] meas_cnt_q, meas_cnt_d;
   logic meas_core_q, meas_core_d;
   logic meas_done_flag_q, meas_done_flag_d;
   logic [bcslm_pkg::RES_W-1:0] result_q, result_d;
   logic meas_end;

   assign meas_end = (meas_state_q == bcslm_pkg::M_RUN) && (meas_cnt_q == MEAS_LAST)
                     && !meas_sel_write;

   always_comb begin
      meas_state_d = meas_state_q;
      meas_cnt_d = meas_cnt_q;
      meas_core_d = meas_core_q;
      result_d = result_q;
      meas_done_flag_d = meas_done_flag_q;
      if (meas_done_clear) begin
         meas_done_flag_d = 1'b0;
      end
      if (meas_sel_write) begin // R2
         meas_state_d = bcslm_pkg::M_RUN;
         meas_cnt_d = '0;
         meas_core_d = meas_core_sel; // R1
      end else begin
         case (meas_state_q)
            bcslm_pkg::M_IDLE: begin
               meas_cnt_d = '0;
            end
            bcslm_pkg::M_RUN: begin
               if (meas_end) begin // R4
                  meas_state_d = bcslm_pkg::M_IDLE;
                  result_d = load_sense_code; // R7 R22
                  meas_done_flag_d = 1'b1; // R5
               end else begin
                  meas_cnt_d = meas_cnt_q + 1'b1;
               end
            end
            default: begin
               meas_state_d = bcslm_pkg::M_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meas_state_q <= bcslm_pkg::M_IDLE;
         meas_cnt_q <= '0;
         meas_core_q <= 1'b0;
         result_q <= '0;
         meas_done_flag_q <= 1'b0;
      end else begin
         meas_state_q <= meas_state_d;
         meas_cnt_q <= meas_cnt_d;
         meas_core_q <= meas_core_d;
         result_q <= result_d;
         meas_done_flag_q <= meas_done_flag_d;
      end
   end

   assign meas_busy = (meas_state_q == bcslm_pkg::M_RUN);
   assign meas_done_flag = meas_done_flag_q;
   assign meas_done_irq = meas_done_flag_q && !meas_done_mask; // R5
   assign load_result_low = result_q[bcslm_pkg::RES_LO_W-1:0]; // R6
   assign load_result_high = result_q[bcslm_pkg::RES_W-1]; // R6

   // Sync clock check, clock choice and sync interrupt
   logic pin_q, pin_d;
   logic [bcslm_pkg::PER_W-1:0] per_q, per_d;
   logic [2:0] good_q, good_d;
   logic valid_q, valid_d;
   logic sync_flag_q, sync_flag_d;
   logic ext_sel_q, ext_sel_d;
   logic [bcslm_pkg::PER_W-1:0] per_min, per_max;
   logic freq_ok, edge_seen;

   assign per_min = per_bound(sync_nominal_freq, bcslm_pkg::TOL_HI_PCT, 1'b1); // R14
   assign per_max = per_bound(sync_nominal_freq, -bcslm_pkg::TOL_LO_PCT, 1'b0); // R14
   assign freq_ok = (sync_nominal_freq >= bcslm_pkg::FREQ_MIN_MHZ)
                    && (sync_nominal_freq <= bcslm_pkg::FREQ_MAX_MHZ); // R13
   assign edge_seen = sync_clock_pin_in && !pin_q && !second_general_output_enable;

   always_comb begin
      pin_d = sync_clock_pin_in;
      per_d = per_q;
      good_d = good_q;
      valid_d = valid_q;
      if (edge_seen) begin
         per_d = bcslm_pkg::PER_W'(1);
         if (freq_ok && (per_q >= per_min) && (per_q <= per_max)) begin // R14
            if (good_q != bcslm_pkg::GOOD_N) begin
               good_d = good_q + 3'h1;
            end
         end else begin
            good_d = 3'h0;
         end
      end else if (per_q > per_max || !freq_ok || second_general_output_enable) begin
         good_d = 3'h0;
      end else begin
         per_d = per_q + 1'b1;
      end
      valid_d = (good_d == bcslm_pkg::GOOD_N);
      ext_sel_d = pll_enable && valid_q; // R11 R23
      sync_flag_d = sync_flag_q;
      if (sync_clk_clear) begin
         sync_flag_d = 1'b0;
      end
      if (pll_enable && (valid_d != valid_q)) begin // R21
         sync_flag_d = 1'b1;
      end
      if (pll_enable && !valid_q && (startup_to_standby || standby_to_active)) begin // R15
         sync_flag_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_q <= 1'b0;
         per_q <= '0;
         good_q <= 3'h0;
         valid_q <= 1'b0;
         sync_flag_q <= 1'b0;
         ext_sel_q <= 1'b0;
      end else begin
         pin_q <= pin_d;
         per_q <= per_d;
         good_q <= good_d;
         valid_q <= valid_d;
         sync_flag_q <= sync_flag_d;
         ext_sel_q <= ext_sel_d;
      end
   end

   assign sync_clock_valid = valid_q;
   assign ext_clk_select = ext_sel_q;
   assign sync_clk_flag = sync_flag_q;
   assign sync_clk_irq = sync_flag_q && !sync_clk_mask; // R12

   // Triangle dither around the centre code
   logic [bcslm_pkg::DIV_W-1:0] div_q, div_d;
   logic [bcslm_pkg::DITHER_W-1:0] dith_q, dith_d;
   logic dir_q, dir_d;
   logic dith_on_q, dith_on_d;

   always_comb begin
      div_d = div_q;
      dith_d = dith_q;
      dir_d = dir_q;
      dith_on_d = freq_dither_enable && !pll_enable && !ext_sel_q; // R8 R9
      if (!dith_on_q) begin
         div_d = '0;
         dith_d = {1'b1, {(bcslm_pkg::DITHER_W-1){1'b0}}};
         dir_d = 1'b0;
      end else if (div_q == bcslm_pkg::DITHER_DIV) begin // R10
         div_d = '0;
         dith_d = dir_q ? dith_q - 1'b1 : dith_q + 1'b1;
         if (dir_q && dith_q == 4'h2) begin
            dir_d = 1'b0;
         end else if (!dir_q && dith_q == 4'he) begin
            dir_d = 1'b1;
         end
      end else begin
         div_d = div_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         div_q <= '0;
         dith_q <= 4'h8;
         dir_q <= 1'b0;
         dith_on_q <= 1'b0;
      end else begin
         div_q <= div_d;
         dith_q <= dith_d;
         dir_q <= dir_d;
         dith_on_q <= dith_on_d;
      end
   end

   assign dither_active = dith_on_q;
   assign dither_code = dith_q;

   // Core settings, mode control and general outputs
   logic [2*bcslm_pkg::CFG_W-1:0] cfg_q, cfg_d;
   logic [1:0] fpwm_q, fpwm_d, pfm_q, pfm_d;
   logic [1:0] out_q, out_d, oen_q, oen_d;

   always_comb begin
      cfg_d = cfg_q;
      for (int i = 0; i < 2; i++) begin
         if (cfg_write[i]) begin // R20
            cfg_d[i*bcslm_pkg::CFG_W +: bcslm_pkg::CFG_W] = cfg_wdata;
         end
         fpwm_d[i] = (meas_busy && (meas_core_q == i[0])); // R3
         pfm_d[i] = light_load[i] && !cfg_q[i*bcslm_pkg::CFG_W + bcslm_pkg::CFG_FPWM_BIT]
                    && !fpwm_d[i]; // R16 R17
      end
      out_d[0] = general_output_value;
      oen_d[0] = drive_oe_n(general_output_value, general_output_push_pull); // R19
      out_d[1] = second_general_output_enable && second_general_output_value; // R18
      oen_d[1] = second_general_output_enable ? drive_oe_n(second_general_output_value,
                 second_general_output_push_pull) : 1'b1; // R19
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_q <= otp_cfg; // R20
         fpwm_q <= 2'h0;
         pfm_q <= 2'h0;
         out_q <= 2'h0;
         oen_q <= 2'h3;
      end else begin
         cfg_q <= cfg_d;
         fpwm_q <= fpwm_d;
         pfm_q <= pfm_d;
         out_q <= out_d;
         oen_q <= oen_d;
      end
   end

   assign core_cfg = cfg_q;
   assign force_pwm = fpwm_q;
   assign pfm_select = pfm_q;
   assign general_output_out = out_q[0];
   assign general_output_oe_n = oen_q[0];
   assign sync_clock_pin_out = out_q[1];
   assign sync_clock_pin_oe_n = oen_q[1];

   sequence s_meas_start;
      meas_sel_write ##1 meas_busy;
   endsequence
   property p_meas_start;
      @(posedge clk) disable iff (rst) meas_sel_write |-> s_meas_start;
   endproperty
   a_meas_start: assert property (p_meas_start) else $error("write did not start"); // R2
   property p_meas_force;
      @(posedge clk) disable iff (rst) meas_busy |=> force_pwm[$past(meas_core_q)];
   endproperty
   a_meas_force: assert property (p_meas_force) else $error("core not forced to pwm"); // R3
   property p_meas_bound;
      @(posedge clk) disable iff (rst) meas_cnt_q <= MEAS_LAST;
   endproperty
   a_meas_bound: assert property (p_meas_bound) else $error("measurement too long"); // R4
   property p_done_flag;
      @(posedge clk) disable iff (rst) meas_end |=> meas_done_flag && !meas_busy;
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("done flag not set"); // R5
   property p_result_hold;
      @(posedge clk) disable iff (rst) !meas_end |=> $stable(result_q);
   endproperty
   a_result_hold: assert property (p_result_hold) else $error("result changed"); // R22
   property p_dither_off;
      @(posedge clk) disable iff (rst) pll_enable |=> !dither_active;
   endproperty
   a_dither_off: assert property (p_dither_off) else $error("dither with pll"); // R8
   property p_sync_mask;
      @(posedge clk) disable iff (rst) sync_clk_mask |-> !sync_clk_irq;
   endproperty
   a_sync_mask: assert property (p_sync_mask) else $error("masked sync irq"); // R12
   property p_no_sync_int;
      @(posedge clk) disable iff (rst) !pll_enable && !sync_flag_q |=> !sync_flag_q;
   endproperty
   a_no_sync_int: assert property (p_no_sync_int) else $error("sync flag without pll"); // R21
   property p_clk_fallback;
      @(posedge clk) disable iff (rst) !valid_q |=> !ext_clk_select;
   endproperty
   a_clk_fallback: assert property (p_clk_fallback) else $error("ext clock kept"); // R23
   property p_fpwm;
      @(posedge clk) disable iff (rst)
         cfg_q[bcslm_pkg::CFG_FPWM_BIT] |=> !pfm_select[0];
   endproperty
   a_fpwm: assert property (p_fpwm) else $error("pfm under forced pwm"); // R17
endmodule : bcslm_top
`default_nettype wire

// [bcslm_sync_src.sv]
// External sync clock source model that drives the sync clock pin
`timescale 1ns/1ns
`default_nettype none
module bcslm_sync_src (
   input wire logic clk,
   input wire logic run,
   input wire logic [7:0] period,
   output logic pin
);
   logic [7:0] cnt_q;
   // Square wave of the given period in clk cycles; stands low when stopped
   always_ff @(posedge clk) begin
      if (!run) begin
         cnt_q <= 8'h00;
         pin <= 1'b0;
      end else begin
         cnt_q <= (cnt_q + 8'h01 >= period) ? 8'h00 : cnt_q + 8'h01;
         pin <= (cnt_q < (period >> 1));
      end
   end
endmodule : bcslm_sync_src
`default_nettype wire

// [tb_bcslm_top.sv]
// Self-checking testbench for the clock sync and load meter block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_bcslm_top;
   localparam int MC = 20;
   logic clk, rst, meas_sel_write, meas_core_sel, meas_done_mask, meas_done_clear;
   logic [8:0] load_sense_code;
   logic meas_done_flag, meas_done_irq, meas_busy, load_result_high;
   logic [7:0] load_result_low;
   logic freq_dither_enable, dither_active;
   logic [3:0] dither_code, code0;
   logic pll_enable, sync_clock_pin_in, sync_clock_pin_out, sync_clock_pin_oe_n;
   logic [4:0] sync_nominal_freq;
   logic sync_clk_mask, sync_clk_clear, startup_to_standby, standby_to_active;
   logic sync_clk_flag, sync_clk_irq, sync_clock_valid, ext_clk_select;
   logic [1:0] light_load, force_pwm, pfm_select, cfg_write;
   logic [43:0] otp_cfg, core_cfg;
   logic [21:0] cfg_wdata;
   logic go_val, go_pp, general_output_out, general_output_oe_n, go2_en;
   logic src_run;
   logic [7:0] src_period;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;

   bcslm_top #(.MEAS_CYCLES(MC)) u_dut (.clk(clk), .rst(rst),
      .meas_sel_write(meas_sel_write), .meas_core_sel(meas_core_sel),
      .load_sense_code(load_sense_code), .meas_done_mask(meas_done_mask),
      .meas_done_clear(meas_done_clear), .meas_done_flag(meas_done_flag),
      .meas_done_irq(meas_done_irq), .meas_busy(meas_busy),
      .load_result_low(load_result_low), .load_result_high(load_result_high),
      .freq_dither_enable(freq_dither_enable), .dither_active(dither_active),
      .dither_code(dither_code), .pll_enable(pll_enable),
      .sync_nominal_freq(sync_nominal_freq), .sync_clock_pin_in(sync_clock_pin_in),
      .sync_clock_pin_out(sync_clock_pin_out), .sync_clock_pin_oe_n(sync_clock_pin_oe_n),
      .sync_clk_mask(sync_clk_mask), .sync_clk_clear(sync_clk_clear),
      .startup_to_standby(startup_to_standby), .standby_to_active(standby_to_active),
      .sync_clk_flag(sync_clk_flag), .sync_clk_irq(sync_clk_irq),
      .sync_clock_valid(sync_clock_valid), .ext_clk_select(ext_clk_select),
      .light_load(light_load), .force_pwm(force_pwm), .pfm_select(pfm_select),
      .otp_cfg(otp_cfg), .cfg_write(cfg_write), .cfg_wdata(cfg_wdata),
      .core_cfg(core_cfg), .general_output_value(go_val),
      .general_output_push_pull(go_pp), .general_output_out(general_output_out),
      .general_output_oe_n(general_output_oe_n),
      .second_general_output_enable(go2_en), .second_general_output_value(go_val),
      .second_general_output_push_pull(go_pp));

   bcslm_sync_src u_src (.clk(clk), .run(src_run), .period(src_period),
      .pin(sync_clock_pin_in));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         test_done();
      end
   end

   task automatic test_done();
      if (n_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // One host write to the measurement select; returns just after the taking edge
   task automatic meas_write(input logic core);
      @(posedge clk);
      meas_sel_write <= 1'b1;
      meas_core_sel <= core;
      @(posedge clk);
      meas_sel_write <= 1'b0;
      #1;
   endtask : meas_write

   // One-cycle strobe: 0 done flag clear, 1 sync clear, 2 startup, other activation
   task automatic pulse(input int sel);
      @(posedge clk);
      case (sel)
         0: meas_done_clear <= 1'b1;
         1: sync_clk_clear <= 1'b1;
         2: startup_to_standby <= 1'b1;
         default: standby_to_active <= 1'b1;
      endcase
      @(posedge clk);
      {meas_done_clear, sync_clk_clear, startup_to_standby, standby_to_active} <= 4'h0;
      step(1);
   endtask : pulse

   task automatic gpo_case(input logic v, input logic pp, input logic oe_n, input logic o);
      @(posedge clk);
      go_val <= v;
      go_pp <= pp;
      step(2);
      `CHK(general_output_oe_n, oe_n)
      `CHK(sync_clock_pin_oe_n, oe_n)
      if (!oe_n) begin
         `CHK(general_output_out, o)
         `CHK(sync_clock_pin_out, o)
      end
   endtask : gpo_case

   initial begin
      rst = 1'b1; meas_sel_write = 1'b0; meas_core_sel = 1'b0; meas_done_mask = 1'b0;
      meas_done_clear = 1'b0; load_sense_code = 9'h1ff; freq_dither_enable = 1'b0;
      pll_enable = 1'b0; sync_nominal_freq = 5'h05; sync_clk_mask = 1'b0;
      sync_clk_clear = 1'b0; startup_to_standby = 1'b0; standby_to_active = 1'b0;
      light_load = 2'b11; cfg_write = 2'b00; cfg_wdata = 22'h000000;
      otp_cfg = {22'h000140, 22'h000040}; go_val = 1'b1; go_pp = 1'b0; go2_en = 1'b0;
      src_run = 1'b0; src_period = 8'h23;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      step(2);
      `CHK(meas_done_flag, 1'b0)
      `CHK(meas_busy, 1'b0)
      `CHK({load_result_high, load_result_low}, 9'h000)
      `CHK(ext_clk_select, 1'b0)
      `CHK(dither_code, 4'h8)
      `CHK(core_cfg, otp_cfg)
      `CHK(pfm_select, 2'b01)
      `CHK(sync_clock_pin_oe_n, 1'b1)
      light_load <= 2'b10;
      step(2);
      `CHK(pfm_select, 2'b00)
      light_load <= 2'b11;
      // Measurement of core 1 at full-scale code
      meas_write(1'b1);
      `CHK(meas_busy, 1'b1)
      step(2);
      `CHK(force_pwm, 2'b10)
      step(MC - 3);
      `CHK(meas_done_flag, 1'b0)
      step(2);
      `CHK(meas_done_flag, 1'b1)
      `CHK(meas_busy, 1'b0)
      `CHK(meas_done_irq, 1'b1)
      `CHK(load_result_low, 8'hff)
      `CHK(load_result_high, 1'b1)
      meas_done_mask <= 1'b1;
      step(1);
      `CHK(meas_done_irq, 1'b0)
      load_sense_code <= 9'h0aa;
      pulse(0);
      step(1);
      `CHK(meas_done_flag, 1'b0)
      `CHK({load_result_high, load_result_low}, 9'h1ff)
      // Write during a run restarts the count on the newly chosen core
      meas_write(1'b1);
      step(10);
      meas_write(1'b0);
      step(3);
      `CHK(force_pwm, 2'b01)
      `CHK(pfm_select, 2'b00)
      step(MC - 4);
      `CHK(meas_done_flag, 1'b0)
      step(2);
      `CHK(meas_done_flag, 1'b1)
      `CHK({load_result_high, load_result_low}, 9'h0aa)
      meas_done_mask <= 1'b0;
      // Register override of the forced PWM default
      @(posedge clk);
      cfg_wdata <= 22'h000140;
      cfg_write <= 2'b01;
      @(posedge clk);
      cfg_write <= 2'b00;
      step(3);
      `CHK(core_cfg[21:0], 22'h000140)
      `CHK(pfm_select, 2'b00)
      // Dither only on the internal oscillator, both cores from one bit
      freq_dither_enable <= 1'b1;
      step(3);
      `CHK(dither_active, 1'b1)
      code0 = dither_code;
      step(40);
      `CHK(dither_code != code0, 1'b1)
      // Slowest valid sync clock for a 5 MHz nominal, PLL on
      pll_enable <= 1'b1;
      src_run <= 1'b1;
      repeat (300) begin
         step(1);
         if (ext_clk_select === 1'b1) break;
      end
      step(2);
      `CHK(sync_clock_valid, 1'b1)
      `CHK(ext_clk_select, 1'b1)
      `CHK(dither_active, 1'b0)
      `CHK(sync_clk_flag, 1'b1)
      `CHK(sync_clk_irq, 1'b1)
      sync_clk_mask <= 1'b1;
      step(1);
      `CHK(sync_clk_irq, 1'b0)
      sync_clk_mask <= 1'b0;
      pulse(1);
      src_run <= 1'b0;
      repeat (120) begin
         step(1);
         if (ext_clk_select === 1'b0) break;
      end
      step(2);
      `CHK(ext_clk_select, 1'b0)
      `CHK(sync_clk_flag, 1'b1)
      // Periods just outside the window never give a valid clock, just inside does
      src_period <= 8'h24;
      src_run <= 1'b1;
      step(300);
      `CHK(sync_clock_valid, 1'b0)
      src_period <= 8'h16;
      step(300);
      `CHK(sync_clock_valid, 1'b0)
      src_period <= 8'h17;
      step(300);
      `CHK(sync_clock_valid, 1'b1)
      src_run <= 1'b0;
      step(50);
      // Missing clock at startup and at activation
      pulse(1);
      pulse(2);
      step(1);
      `CHK(sync_clk_flag, 1'b1)
      pulse(1);
      pulse(3);
      step(1);
      `CHK(sync_clk_flag, 1'b1)
      pll_enable <= 1'b0;
      pulse(1);
      pulse(3);
      step(1);
      `CHK(sync_clk_flag, 1'b0)
      // General outputs, the sync pin reused as the second one
      go2_en <= 1'b1;
      gpo_case(1'b1, 1'b0, 1'b1, 1'b1);
      gpo_case(1'b0, 1'b0, 1'b0, 1'b0);
      gpo_case(1'b1, 1'b1, 1'b0, 1'b1);
      test_done();
   end
endmodule : tb_bcslm_top
`default_nettype wire
